// ==== design/stack_addr_pkg.sv ====
package stack_addr_pkg;
  // Register offsets in the special register space
  localparam logic [7:0]  PTR_LOW_OFFSET   = 8'h81;
  localparam logic [7:0]  PTR_EXT_OFFSET   = 8'hef;
  localparam logic [7:0]  AUX2_OFFSET      = 8'ha2;
  // Reset values
  localparam logic [7:0]  PTR_LOW_RESET    = 8'h07;
  localparam logic [2:0]  PTR_EXT_RESET    = 3'h0;
  localparam logic        EXT_SEL_RESET    = 1'b0;
  // Field layout
  localparam int          EXT_SEL_BIT      = 4;
  localparam int          EXT_BITS         = 3;
  localparam int          PTR_BITS         = 11;
  // Extra RAM window for the extended stack, pointer steps and zero byte
  localparam logic [10:0] ERAM_BASE        = 11'h000;
  localparam logic [10:0] ERAM_TOP         = 11'h7ff;
  localparam logic [7:0]  LOW_STEP         = 8'h01;
  localparam logic [10:0] PTR_STEP         = 11'h001;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACC,
    ST_CAPT
  } stack_state_e;
endpackage : stack_addr_pkg

// ==== design/stack_addr_unit.sv ====
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// - With the extended stack off, stack accesses go to the 256-byte scratch memory addressed by the 8-bit pointer only.
// - Setting the extended stack select bit in auxiliary control two moves stack accesses to the extended stack.
// - The extended stack lives in the on-chip extra RAM and may use up to 2KB of it.
// - In extended mode the address is 11 bits: stack pointer low byte plus the three low extension bits.
// - One stack pointer register serves both stack spaces.
// - Stack growth never crosses between the scratch stack and the extended stack.
// - The extension register does not affect addressing while the select bit is 0.
// - With the extended stack on, each stack access takes one extra cycle.
// - Extended stack accesses go only to the on-chip extra RAM, never to external data memory.
// - Extended stack accesses reach the extra RAM even when data access to it is disabled or the nonvolatile map overlays it.
// - The extra RAM holding the extended stack spans 0000H to 07FFH of the data space.
module stack_addr_unit
  import stack_addr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Core stack requests
  input  wire logic        stk_req,
  input  wire logic        stk_push,
  input  wire logic [7:0]  stk_wdata,
  output logic             stk_ready,
  output logic             stk_done,
  output logic [7:0]       stk_rdata,
  // Internal scratch memory
  output logic [7:0]       scratch_addr,
  output logic             scratch_wr,
  output logic             scratch_rd,
  output logic [7:0]       scratch_wdata,
  input  wire logic [7:0]  scratch_rdata,
  // On-chip extra RAM
  output logic [10:0]      eram_addr,
  output logic             eram_wr,
  output logic             eram_rd,
  output logic [7:0]       eram_wdata,
  input  wire logic [7:0]  eram_rdata
);

  stack_state_e state_reg, state_next;

  logic [7:0]          ptr_low_reg;
  logic [EXT_BITS-1:0] ext_bits_reg;
  logic                ext_sel_reg;
  logic                mode_ext_reg;
  logic                push_reg;
  logic [7:0]          wdata_reg;
  logic [10:0]         op_ptr_reg;
  logic [7:0]          reg_rdata_reg;
  logic [7:0]          stk_rdata_reg;
  logic                stk_done_reg;
  logic [7:0]          scratch_addr_reg;
  logic                scratch_wr_reg;
  logic                scratch_rd_reg;
  logic [10:0]         eram_addr_reg;
  logic                eram_wr_reg;
  logic                eram_rd_reg;
  logic [7:0]          mem_wdata_reg;

  // Decode and pointer arithmetic
  wire                 accept      = stk_req && (state_reg == ST_IDLE);
  wire                 sel_low     = (reg_addr == PTR_LOW_OFFSET);
  wire                 sel_ext     = (reg_addr == PTR_EXT_OFFSET);
  wire                 sel_aux2    = (reg_addr == AUX2_OFFSET);
  wire [10:0]          ptr_full    = {ext_bits_reg, ptr_low_reg};
  wire [7:0]           low_inc     = ptr_low_reg + LOW_STEP;
  wire [7:0]           low_dec     = ptr_low_reg - LOW_STEP;
  wire [10:0]          ptr_inc     = ptr_full + PTR_STEP;
  wire [10:0]          ptr_dec     = ptr_full - PTR_STEP;
  // Scratch mode wraps inside 8 bits and leaves the extension bits alone
  wire [7:0]           low_scr_new = stk_push ? low_inc : low_dec;
  wire [10:0]          ptr_ext_new = stk_push ? ptr_inc : ptr_dec;
  // Push addresses the incremented slot, pop the current one
  wire [7:0]           scr_acc     = stk_push ? low_inc : ptr_low_reg;
  wire [10:0]          ext_acc     = stk_push ? ptr_inc : ptr_full;
  wire [10:0]          acc_ptr     = ext_sel_reg ? ext_acc : {3'h0, scr_acc};
  wire                 enter_acc   = (state_next == ST_ACC) && (state_reg != ST_ACC);
  wire [7:0]           aux2_view   = ZERO_BYTE | (8'(ext_sel_reg) << EXT_SEL_BIT);
  wire [7:0]           ext_view    = {5'h00, ext_bits_reg};
  wire [7:0]           rd_mux      = sel_low  ? ptr_low_reg :
                                     sel_ext  ? ext_view :
                                     sel_aux2 ? aux2_view : ZERO_BYTE;
  wire [7:0]           mem_rdata   = mode_ext_reg ? eram_rdata : scratch_rdata;

  // Extended mode inserts one wait state per access
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ext_sel_reg ? ST_WAIT : ST_ACC;
        end
      end
      ST_WAIT: state_next = ST_ACC;
      ST_ACC:  state_next = ST_CAPT;
      ST_CAPT: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Shared pointer; a stack step beats a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_low_reg  <= PTR_LOW_RESET;
      ext_bits_reg <= PTR_EXT_RESET;
    end else if (accept && ext_sel_reg) begin
      ptr_low_reg  <= ptr_ext_new[7:0];
      ext_bits_reg <= ptr_ext_new[PTR_BITS-1:8];
    end else if (accept) begin
      ptr_low_reg  <= low_scr_new;
    end else if (reg_wr && sel_low) begin
      ptr_low_reg  <= reg_wdata;
    end else if (reg_wr && sel_ext) begin
      ext_bits_reg <= reg_wdata[EXT_BITS-1:0];
    end
  end

  // Mode bit is latched per access so a mid-access switch cannot split it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_sel_reg <= EXT_SEL_RESET;
    end else if (reg_wr && sel_aux2) begin
      ext_sel_reg <= reg_wdata[EXT_SEL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_ext_reg <= 1'b0;
      push_reg     <= 1'b0;
      wdata_reg    <= ZERO_BYTE;
      op_ptr_reg   <= ERAM_BASE;
    end else if (accept) begin
      mode_ext_reg <= ext_sel_reg;
      push_reg     <= stk_push;
      wdata_reg    <= stk_wdata;
      op_ptr_reg   <= acc_ptr;
    end
  end

  // Memory strobes stand for the one access cycle only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scratch_addr_reg <= ZERO_BYTE;
      scratch_wr_reg   <= 1'b0;
      scratch_rd_reg   <= 1'b0;
      eram_addr_reg    <= ERAM_BASE;
      eram_wr_reg      <= 1'b0;
      eram_rd_reg      <= 1'b0;
      mem_wdata_reg    <= ZERO_BYTE;
    end else begin
      scratch_wr_reg <= 1'b0;
      scratch_rd_reg <= 1'b0;
      eram_wr_reg    <= 1'b0;
      eram_rd_reg    <= 1'b0;
      if (enter_acc) begin
        mem_wdata_reg <= accept ? stk_wdata : wdata_reg;
        if (accept) begin
          scratch_addr_reg <= acc_ptr[7:0];
          scratch_wr_reg   <= stk_push;
          scratch_rd_reg   <= !stk_push;
        end else begin
          // Extra RAM is driven regardless of data-side disable or overlay
          eram_addr_reg <= ERAM_BASE + op_ptr_reg;
          eram_wr_reg   <= push_reg;
          eram_rd_reg   <= !push_reg;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stk_rdata_reg <= ZERO_BYTE;
      stk_done_reg  <= 1'b0;
    end else begin
      stk_done_reg <= (state_reg == ST_CAPT);
      if ((state_reg == ST_CAPT) && !push_reg) begin
        stk_rdata_reg <= mem_rdata;
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata_reg <= ZERO_BYTE;
    end else begin
      reg_rdata_reg <= reg_rd ? rd_mux : ZERO_BYTE;
    end
  end

  assign reg_rdata     = reg_rdata_reg;
  assign stk_ready     = (state_reg == ST_IDLE);
  assign stk_done      = stk_done_reg;
  assign stk_rdata     = stk_rdata_reg;
  assign scratch_addr  = scratch_addr_reg;
  assign scratch_wr    = scratch_wr_reg;
  assign scratch_rd    = scratch_rd_reg;
  assign scratch_wdata = mem_wdata_reg;
  assign eram_addr     = eram_addr_reg;
  assign eram_wr       = eram_wr_reg;
  assign eram_rd       = eram_rd_reg;
  assign eram_wdata    = mem_wdata_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence scr_accept_s;
    accept && !ext_sel_reg;
  endsequence

  sequence ext_accept_s;
    accept && ext_sel_reg;
  endsequence

  sequence ext_latency_s;
    !stk_done ##1 !stk_done ##1 !stk_done ##1 stk_done;
  endsequence

  scratch_only_a: assert property (
    scr_accept_s |=> (scratch_wr || scratch_rd) && !eram_wr && !eram_rd
  ) else $error("scratch access leaked to extra RAM");

  ext_route_a: assert property (
    ext_accept_s |=> !eram_wr && !eram_rd ##1 (eram_wr || eram_rd) && !scratch_wr && !scratch_rd
  ) else $error("extended access not routed to extra RAM");

  ext_address_a: assert property (
    ext_accept_s ##1 !(reg_wr && (sel_low || sel_ext)) |=>
      eram_addr == ERAM_BASE + (push_reg ? $past(ptr_full) : $past(ptr_full) + PTR_STEP)
  ) else $error("extended address not formed from pointer");

  ext_penalty_a: assert property (
    ext_accept_s |=> ext_latency_s
  ) else $error("extended access lacks extra cycle");

  scr_latency_a: assert property (
    scr_accept_s |=> !stk_done ##1 !stk_done ##1 stk_done
  ) else $error("scratch access latency wrong");

  no_cross_a: assert property (
    scr_accept_s |=> ext_bits_reg == $past(ext_bits_reg)
  ) else $error("scratch step changed extension bits");

  ext_carry_a: assert property (
    ext_accept_s |=> ptr_full == (push_reg ? $past(ptr_full) + PTR_STEP : $past(ptr_full) - PTR_STEP)
  ) else $error("extended pointer step lost carry");

  ext_ignored_a: assert property (
    scr_accept_s and stk_push |=> scratch_addr == $past(ptr_low_reg) + LOW_STEP
  ) else $error("scratch address depends on extension");

  eram_window_a: assert property (
    (eram_wr || eram_rd) |-> (eram_addr <= ERAM_TOP) && mode_ext_reg
  ) else $error("extra RAM access outside window");

  ptr_readback_a: assert property (
    reg_rd && sel_low |=> reg_rdata == $past(ptr_low_reg)
  ) else $error("pointer readback wrong");

  scr_pop_addr_a: assert property (
    scr_accept_s and !stk_push |=> scratch_addr == $past(ptr_low_reg)
  ) else $error("scratch pop address wrong");

  scr_step_a: assert property (
    scr_accept_s |=> ptr_low_reg == ($past(stk_push) ? $past(ptr_low_reg) + LOW_STEP :
                                                       $past(ptr_low_reg) - LOW_STEP)
  ) else $error("scratch pointer step wrong");

  scr_data_a: assert property (
    scr_accept_s and stk_push |=> scratch_wr && (scratch_wdata == $past(stk_wdata))
  ) else $error("scratch push data lost");

  ext_data_a: assert property (
    ext_accept_s and stk_push |=> ##1 eram_wr && (eram_wdata == $past(stk_wdata, 2))
  ) else $error("extended push data lost");

  sel_write_a: assert property (
    reg_wr && sel_aux2 |=> ext_sel_reg == $past(reg_wdata[EXT_SEL_BIT])
  ) else $error("select bit write lost");

  busy_hold_a: assert property (
    accept |=> !stk_ready
  ) else $error("ready during access");

  done_pulse_a: assert property (
    stk_done |=> !stk_done
  ) else $error("done longer than one cycle");

endmodule : stack_addr_unit

// ==== sim/stack_mem_model.sv ====
`timescale 1ns/1ns
module stack_mem_model (
  // Clock
  input  wire logic        sys_clk,
  // Scratch memory side
  input  wire logic [7:0]  scratch_addr,
  input  wire logic        scratch_wr,
  input  wire logic        scratch_rd,
  input  wire logic [7:0]  scratch_wdata,
  output logic [7:0]       scratch_rdata,
  // Extra RAM side
  input  wire logic [10:0] eram_addr,
  input  wire logic        eram_wr,
  input  wire logic        eram_rd,
  input  wire logic [7:0]  eram_wdata,
  output logic [7:0]       eram_rdata
);
  logic [7:0] smem [256];
  logic [7:0] emem [2048];
  // Data flips outside the read cycle so a late sample never matches by luck
  always @(posedge sys_clk) begin
    if (scratch_wr) smem[scratch_addr] <= scratch_wdata;
    scratch_rdata <= scratch_rd ? smem[scratch_addr] : ~scratch_rdata;
    if (eram_wr) emem[eram_addr] <= eram_wdata;
    eram_rdata <= eram_rd ? emem[eram_addr] : ~eram_rdata;
  end
endmodule : stack_mem_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import stack_addr_pkg::*;
;
  logic        sys_clk, srst, reg_wr, reg_rd, stk_req, stk_push, xs;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, stk_wdata, stk_rdata, v, sv;
  logic        stk_ready, stk_done, scratch_wr, scratch_rd, eram_wr, eram_rd;
  logic [7:0]  scratch_addr, scratch_wdata, scratch_rdata, eram_wdata, eram_rdata;
  logic [10:0] eram_addr, ptr;
  int          miscompares, n_tests, cyc;

  stack_addr_unit DUT (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .stk_req, .stk_push, .stk_wdata, .stk_ready, .stk_done, .stk_rdata, .scratch_addr,
    .scratch_wr, .scratch_rd, .scratch_wdata, .scratch_rdata, .eram_addr, .eram_wr,
    .eram_rd, .eram_wdata, .eram_rdata);
  stack_mem_model mem (.sys_clk, .scratch_addr, .scratch_wr, .scratch_rd, .scratch_wdata,
    .scratch_rdata, .eram_addr, .eram_wr, .eram_rd, .eram_wdata, .eram_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Pointer step of the reference: 11-bit wrap when extended, low byte only otherwise
  function automatic logic [10:0] step(input logic [10:0] p, input logic push, input logic ext);
    logic [10:0] r;
    r = push ? p + PTR_STEP : p - PTR_STEP;
    return ext ? r : {p[10:8], r[7:0]};
  endfunction : step

  task automatic regs_chk();
    rd(PTR_LOW_OFFSET, v);
    chk(11'(v), 11'(ptr[7:0]), "pointer");
    rd(PTR_EXT_OFFSET, v);
    chk(11'(v), 11'(ptr[10:8]), "extension");
    rd(AUX2_OFFSET, v);
    chk(11'(v), 11'({xs, 4'h0}), "select");
  endtask : regs_chk

  task automatic set_ptr(input logic [10:0] p);
    wr(PTR_LOW_OFFSET, p[7:0]);
    wr(PTR_EXT_OFFSET, {5'h15, p[10:8]});
    ptr = p;
  endtask : set_ptr

  task automatic stack_op(input logic push, input logic [7:0] d);
    int          n;
    logic [10:0] a, ea;
    logic [7:0]  w;
    logic [1:0]  hit;
    logic        busy;
    ea = push ? step(ptr, 1'b1, xs) : ptr;
    if (!xs) ea[10:8] = 3'h0;
    ptr = step(ptr, push, xs);
    @(posedge sys_clk);
    stk_req   <= 1'b1;
    stk_push  <= push;
    stk_wdata <= d;
    @(posedge sys_clk);
    stk_req   <= 1'b0;
    n   = 1;
    hit = 2'b00;
    forever begin
      #1;
      if (n == 1) busy = stk_ready;
      if (scratch_wr === 1'b1 || scratch_rd === 1'b1) begin
        hit[0] = 1'b1;
        a = {3'h0, scratch_addr};
        w = scratch_wdata;
      end
      if (eram_wr === 1'b1 || eram_rd === 1'b1) begin
        hit[1] = 1'b1;
        a = eram_addr;
        w = eram_wdata;
      end
      if (stk_done === 1'b1 || n > 8) break;
      @(posedge sys_clk);
      n++;
    end
    chk(11'(n), xs ? 11'h004 : 11'h003, "latency");
    chk(11'({busy, stk_ready}), 11'h001, "ready");
    chk(11'(hit), xs ? 11'h002 : 11'h001, "target");
    chk(a, ea, "address");
    if (push) chk(11'(w), 11'(d), "push data");
    else chk(11'(stk_rdata), 11'(d), "pop data");
  endtask : stack_op

  task automatic burst(input int k);
    logic [7:0] q[$];
    logic [7:0] d;
    for (int i = 0; i < k; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      stack_op(1'b1, d);
    end
    for (int i = 0; i < k; i++) begin
      d = q.pop_back();
      stack_op(1'b0, d);
    end
    regs_chk();
  endtask : burst

  initial begin
    srst        = 1'b1;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = ZERO_BYTE;
    reg_wdata   = ZERO_BYTE;
    stk_req     = 1'b0;
    stk_push    = 1'b0;
    stk_wdata   = ZERO_BYTE;
    miscompares = 0;
    n_tests     = 0;
    ptr         = {PTR_EXT_RESET, PTR_LOW_RESET};
    xs          = EXT_SEL_RESET;
    void'($urandom(7));
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    regs_chk();
    rd(8'h00, v);
    chk(11'(v), 11'h000, "unmapped");
    $display("test registers done");
    // Extension bits set while off must not reach the address
    set_ptr({3'h5, 8'hfe});
    burst(4);
    repeat (3) begin
      set_ptr(11'($urandom));
      burst(1 + $urandom % 6);
    end
    $display("test scratch stack done");
    // Scratch pointer low byte saved for the switch back; no requests in flight while swapping
    sv = ptr[7:0];
    wr(AUX2_OFFSET, 8'h10);
    xs = 1'b1;
    set_ptr(11'h7fe);
    burst(4);
    repeat (3) begin
      set_ptr(11'($urandom));
      burst(1 + $urandom % 6);
    end
    $display("test extended stack done");
    wr(AUX2_OFFSET, 8'h00);
    xs = 1'b0;
    set_ptr({ptr[10:8], sv});
    burst(3);
    $display("test switch back done");
    give_verdict();
  end
endmodule : tb_top
